// [logic/spi_port.sv]
// serial peripheral port, master or slave, full duplex or single wire
// assumes all inputs synchronous to CORE_CLK_IN except the slave serial clock
// Behaviour
// - master alone starts; shifter exchanges with partner
// - written byte waits, loads at transfer start
// - completed byte moves into receive buffer
// - master drives clock and MOSI, samples MISO
// - slave takes clock, drives MISO, samples MOSI
// - prescaler divides bus clock by 1..8
// - rate field divides further by 2..256
// - disabled port drives none of four pins
// - dual wire: MOSI master out, MISO in
// - single wire master uses MOSI, releases MISO
// - single wire slave uses MISO, releases MOSI
// - slave select is input in slave mode
// - master without fault detect ignores select pin
// - master fault detect: fault input or auto select
// - stop disables port; deep stop resets it
// - light stop freezes state, resumes afterwards
// - five byte-wide register groups as ports
// - disable aborts, empties buffers, fixes flags
// - polarity bit sets clock idle level
// - phase bit picks sampling edge
// - bit order selects msb or lsb first
`timescale 1ns/1ps
module spi_port #(
   parameter int DATA_W = spi_port_pkg::DATA_W,
   parameter int FIFO_DEPTH = spi_port_pkg::TX_FIFO_DEPTH
) (
   input wire logic CORE_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic LIGHT_STOP_IN,
   input wire logic DEEP_STOP_IN,
   input wire logic PORT_ENABLE_IN,
   input wire logic MASTER_MODE_IN,
   input wire logic CLOCK_IDLE_POLARITY_IN,
   input wire logic CLOCK_EDGE_PHASE_IN,
   input wire logic LOW_BIT_FIRST_IN,
   input wire logic SINGLE_WIRE_SELECT_IN,
   input wire logic HALF_DUPLEX_DRIVE_ENABLE_IN,
   input wire logic FAULT_DETECT_ENABLE_IN,
   input wire logic SELECT_OUTPUT_ENABLE_IN,
   input wire logic [spi_port_pkg::SEL_W-1:0] PRESCALE_SELECT_IN,
   input wire logic [spi_port_pkg::SEL_W-1:0] RATE_DIVIDER_SELECT_IN,
   input wire logic TX_VALID_IN,
   input wire logic [DATA_W-1:0] TX_DATA_IN,
   output logic TX_READY_OUT,
   output logic TRANSMIT_EMPTY_FLAG_OUT,
   output logic [DATA_W-1:0] RX_DATA_OUT,
   output logic RECEIVE_FULL_FLAG_OUT,
   input wire logic RX_READ_IN,
   output logic MODE_FAULT_OUT,
   input wire logic MODE_FAULT_CLEAR_IN,
   input wire logic SERIAL_CLOCK_PIN_IN,
   output logic SERIAL_CLOCK_PIN_OUT,
   output logic SERIAL_CLOCK_PIN_OE_OUT,
   input wire logic MOSI_IN,
   output logic MOSI_OUT,
   output logic MOSI_OE_OUT,
   input wire logic MISO_IN,
   output logic MISO_OUT,
   output logic MISO_OE_OUT,
   input wire logic SLAVE_SELECT_IN,
   output logic SLAVE_SELECT_OUT,
   output logic SLAVE_SELECT_OE_OUT
);
   localparam int EW = spi_port_pkg::EDGE_W;

   spi_port_pkg::state_t state_reg;
   logic [DATA_W-1:0] shift_reg, tx_buf_reg;
   logic [EW-1:0] edge_reg, edge_next;
   logic sample_reg, sck_lvl_reg;
   logic sck_s1_reg, sck_s2_reg, sck_s3_reg, din_d1_reg, din_d2_reg;
   logic clr, freeze, en, ss_low, din_raw, bit_in, half_tick;
   logic start_m, start_s, ev, done, fault_ev, slave_abort;
   logic fifo_valid, fifo_ready;
   logic [DATA_W-1:0] fifo_data;

   // ************************************************************
   // shifter helpers
   // ************************************************************
   function automatic logic out_bit(input logic [DATA_W-1:0] v, input logic lsb);
      return lsb ? v[0] : v[DATA_W-1];
   endfunction

   function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] v,
                                                  input logic b, input logic lsb);
      return lsb ? {b, v[DATA_W-1:1]} : {v[DATA_W-2:0], b};
   endfunction

   // ************************************************************
   // mode decode
   // ************************************************************
   // deep stop loses everything, light stop halts and releases the pins but keeps state
   assign clr = !RST_N_IN || DEEP_STOP_IN;
   assign freeze = LIGHT_STOP_IN;
   assign en = PORT_ENABLE_IN && !LIGHT_STOP_IN;
   assign ss_low = !SLAVE_SELECT_IN;

   // single wire swaps which pin carries incoming data
   always_comb
   begin
      if (MASTER_MODE_IN)
         din_raw = SINGLE_WIRE_SELECT_IN ? MOSI_IN : MISO_IN;
      else
         din_raw = SINGLE_WIRE_SELECT_IN ? MISO_IN : MOSI_IN;
   end

   // the slave data is delayed to line up with the synchronised clock
   assign bit_in = MASTER_MODE_IN ? din_raw : din_d2_reg;

   assign start_m = state_reg == spi_port_pkg::ST_IDLE && en && MASTER_MODE_IN
                    && !TRANSMIT_EMPTY_FLAG_OUT && !MODE_FAULT_OUT;
   assign start_s = state_reg == spi_port_pkg::ST_IDLE && en && !MASTER_MODE_IN
                    && ss_low;
   assign slave_abort = state_reg == spi_port_pkg::ST_SLAVE && !ss_low;
   assign fault_ev = en && MASTER_MODE_IN && FAULT_DETECT_ENABLE_IN
                     && !SELECT_OUTPUT_ENABLE_IN && ss_low;
   assign ev = !freeze && ((state_reg == spi_port_pkg::ST_MASTER && half_tick)
               || (state_reg == spi_port_pkg::ST_SLAVE && ss_low
                   && sck_s2_reg != sck_s3_reg));
   assign edge_next = edge_reg + spi_port_pkg::FIRST_EDGE;
   assign done = ev && edge_next == spi_port_pkg::EDGES_PER_BYTE;

   // ************************************************************
   // slave clock synchroniser
   // ************************************************************
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (clr)
      begin
         sck_s1_reg <= spi_port_pkg::PIN_IDLE;
         sck_s2_reg <= spi_port_pkg::PIN_IDLE;
         sck_s3_reg <= spi_port_pkg::PIN_IDLE;
         din_d1_reg <= spi_port_pkg::PIN_IDLE;
         din_d2_reg <= spi_port_pkg::PIN_IDLE;
      end
      else
      begin
         sck_s1_reg <= SERIAL_CLOCK_PIN_IN;
         sck_s2_reg <= sck_s1_reg;
         sck_s3_reg <= sck_s2_reg;
         din_d1_reg <= din_raw;
         din_d2_reg <= din_d1_reg;
      end
   end

   // ************************************************************
   // bit-rate generator and transmit fifo
   // ************************************************************
   bit_rate_gen u_rate (
      .clk_in(CORE_CLK_IN),
      .clr_in(clr),
      .run_in(state_reg == spi_port_pkg::ST_MASTER),
      .hold_in(freeze),
      .prescale_in(PRESCALE_SELECT_IN),
      .rate_in(RATE_DIVIDER_SELECT_IN),
      .half_tick_out(half_tick)
   );

   // writes offered during light stop are dropped while TX_READY_OUT can still show ready
   assign fifo_ready = TRANSMIT_EMPTY_FLAG_OUT && en && !freeze;

   tx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in(CORE_CLK_IN),
      .clr_in(clr),
      .flush_in(!PORT_ENABLE_IN && !freeze),
      .in_valid_in(TX_VALID_IN && !freeze),
      .in_data_in(TX_DATA_IN),
      .in_ready_out(TX_READY_OUT),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_data),
      .out_ready_in(fifo_ready)
   );

   // ************************************************************
   // transfer engine
   // ************************************************************
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (clr)
      begin
         state_reg <= spi_port_pkg::ST_IDLE;
         shift_reg <= spi_port_pkg::DATA_RESET;
         edge_reg <= spi_port_pkg::EDGE_ZERO;
         sample_reg <= spi_port_pkg::PIN_IDLE;
         sck_lvl_reg <= spi_port_pkg::PIN_IDLE;
      end
      else if (freeze)
         state_reg <= state_reg;
      else if (!PORT_ENABLE_IN || fault_ev || slave_abort)
      begin
         state_reg <= spi_port_pkg::ST_IDLE;
         edge_reg <= spi_port_pkg::EDGE_ZERO;
         sck_lvl_reg <= spi_port_pkg::PIN_IDLE;
      end
      else
      begin
         unique case (state_reg)
            spi_port_pkg::ST_IDLE:
            begin
               if (start_m)
               begin
                  shift_reg <= tx_buf_reg;
                  state_reg <= spi_port_pkg::ST_MASTER;
               end
               else if (start_s)
               begin
                  if (!TRANSMIT_EMPTY_FLAG_OUT)
                     shift_reg <= tx_buf_reg;
                  state_reg <= spi_port_pkg::ST_SLAVE;
               end
               edge_reg <= spi_port_pkg::EDGE_ZERO;
            end
            spi_port_pkg::ST_MASTER, spi_port_pkg::ST_SLAVE:
            begin
               if (ev)
               begin
                  edge_reg <= edge_next;
                  if (state_reg == spi_port_pkg::ST_MASTER)
                     sck_lvl_reg <= !sck_lvl_reg;
                  if (!CLOCK_EDGE_PHASE_IN)
                  begin
                     // phase 0: sample on leading, shift on trailing
                     if (edge_next[0])
                        sample_reg <= bit_in;
                     else
                        shift_reg <= shift_in(shift_reg, sample_reg, LOW_BIT_FIRST_IN);
                  end
                  else if (edge_next[0])
                  begin
                     if (edge_next != spi_port_pkg::FIRST_EDGE)
                        shift_reg <= shift_in(shift_reg, sample_reg, LOW_BIT_FIRST_IN);
                  end
                  else if (done)
                     shift_reg <= shift_in(shift_reg, bit_in, LOW_BIT_FIRST_IN);
                  else
                     sample_reg <= bit_in;
                  if (done)
                     state_reg <= spi_port_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // transmit buffer
   // ************************************************************
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (clr)
      begin
         tx_buf_reg <= spi_port_pkg::DATA_RESET;
         TRANSMIT_EMPTY_FLAG_OUT <= 1'b1;
      end
      else if (!freeze)
      begin
         if (!PORT_ENABLE_IN)
            TRANSMIT_EMPTY_FLAG_OUT <= 1'b1;
         else if (fifo_valid && fifo_ready)
         begin
            tx_buf_reg <= fifo_data;
            TRANSMIT_EMPTY_FLAG_OUT <= 1'b0;
         end
         else if ((start_m || start_s) && !fault_ev)
            TRANSMIT_EMPTY_FLAG_OUT <= 1'b1;
      end
   end

   // ************************************************************
   // receive buffer and fault flag
   // ************************************************************
   // a completed byte in the same cycle as a read keeps the flag set
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (clr)
      begin
         RX_DATA_OUT <= spi_port_pkg::DATA_RESET;
         RECEIVE_FULL_FLAG_OUT <= 1'b0;
      end
      else if (!freeze)
      begin
         if (!PORT_ENABLE_IN)
            RECEIVE_FULL_FLAG_OUT <= 1'b0;
         else if (done)
         begin
            RX_DATA_OUT <= (CLOCK_EDGE_PHASE_IN && !edge_next[0])
                           ? shift_in(shift_reg, bit_in, LOW_BIT_FIRST_IN)
                           : shift_in(shift_reg, sample_reg, LOW_BIT_FIRST_IN);
            RECEIVE_FULL_FLAG_OUT <= 1'b1;
         end
         else if (RX_READ_IN)
            RECEIVE_FULL_FLAG_OUT <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (clr)
         MODE_FAULT_OUT <= 1'b0;
      else if (!freeze)
      begin
         if (fault_ev)
            MODE_FAULT_OUT <= 1'b1;
         else if (MODE_FAULT_CLEAR_IN)
            MODE_FAULT_OUT <= 1'b0;
      end
   end

   // ************************************************************
   // pin multiplexing
   // ************************************************************
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (clr)
      begin
         SERIAL_CLOCK_PIN_OUT <= spi_port_pkg::PIN_IDLE;
         SERIAL_CLOCK_PIN_OE_OUT <= 1'b0;
         MOSI_OUT <= spi_port_pkg::PIN_IDLE;
         MOSI_OE_OUT <= 1'b0;
         MISO_OUT <= spi_port_pkg::PIN_IDLE;
         MISO_OE_OUT <= 1'b0;
         SLAVE_SELECT_OUT <= spi_port_pkg::SELECT_IDLE;
         SLAVE_SELECT_OE_OUT <= 1'b0;
      end
      else
      begin
         SERIAL_CLOCK_PIN_OUT <= CLOCK_IDLE_POLARITY_IN ^ sck_lvl_reg;
         SERIAL_CLOCK_PIN_OE_OUT <= en && MASTER_MODE_IN;
         MOSI_OUT <= out_bit(shift_reg, LOW_BIT_FIRST_IN);
         MOSI_OE_OUT <= en && MASTER_MODE_IN
                        && (!SINGLE_WIRE_SELECT_IN || HALF_DUPLEX_DRIVE_ENABLE_IN);
         MISO_OUT <= out_bit(shift_reg, LOW_BIT_FIRST_IN);
         MISO_OE_OUT <= en && !MASTER_MODE_IN && ss_low
                        && (!SINGLE_WIRE_SELECT_IN || HALF_DUPLEX_DRIVE_ENABLE_IN);
         SLAVE_SELECT_OUT <= state_reg != spi_port_pkg::ST_MASTER;
         SLAVE_SELECT_OE_OUT <= en && MASTER_MODE_IN && FAULT_DETECT_ENABLE_IN
                                && SELECT_OUTPUT_ENABLE_IN;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   a_disable_flags: assert property (@(posedge CORE_CLK_IN) disable iff (clr)
      !PORT_ENABLE_IN && !freeze |=> TRANSMIT_EMPTY_FLAG_OUT && !RECEIVE_FULL_FLAG_OUT
      && state_reg == spi_port_pkg::ST_IDLE)
      else $error("disable did not clear buffers and state");
   a_pins_released: assert property (@(posedge CORE_CLK_IN) disable iff (clr)
      !en |=> !SERIAL_CLOCK_PIN_OE_OUT && !MOSI_OE_OUT && !MISO_OE_OUT && !SLAVE_SELECT_OE_OUT)
      else $error("disabled port still drives a pin");
   a_slave_select_in: assert property (@(posedge CORE_CLK_IN) disable iff (clr)
      !MASTER_MODE_IN |=> !SLAVE_SELECT_OE_OUT && !SERIAL_CLOCK_PIN_OE_OUT)
      else $error("slave drives select or clock");
   a_select_unused: assert property (@(posedge CORE_CLK_IN) disable iff (clr)
      MASTER_MODE_IN && !FAULT_DETECT_ENABLE_IN |=> !SLAVE_SELECT_OE_OUT)
      else $error("select pin driven without fault detect");
   a_dual_wire_dir: assert property (@(posedge CORE_CLK_IN) disable iff (clr)
      en && MASTER_MODE_IN && !SINGLE_WIRE_SELECT_IN |=> MOSI_OE_OUT && !MISO_OE_OUT)
      else $error("master data pin direction wrong");
   a_single_master: assert property (@(posedge CORE_CLK_IN) disable iff (clr)
      en && MASTER_MODE_IN && SINGLE_WIRE_SELECT_IN
      |=> !MISO_OE_OUT && MOSI_OE_OUT == $past(HALF_DUPLEX_DRIVE_ENABLE_IN))
      else $error("single wire master pin use wrong");
   a_single_slave: assert property (@(posedge CORE_CLK_IN) disable iff (clr)
      en && !MASTER_MODE_IN && SINGLE_WIRE_SELECT_IN |=> !MOSI_OE_OUT)
      else $error("single wire slave drives the master pin");
   a_load_start: assert property (@(posedge CORE_CLK_IN) disable iff (clr)
      start_m && !fault_ev |=> shift_reg == $past(tx_buf_reg) && TRANSMIT_EMPTY_FLAG_OUT)
      else $error("transmit buffer not loaded at start");
   a_rx_capture: assert property (@(posedge CORE_CLK_IN) disable iff (clr)
      done && PORT_ENABLE_IN |=> RECEIVE_FULL_FLAG_OUT)
      else $error("completed byte not flagged");
   a_sck_idle_after: assert property (@(posedge CORE_CLK_IN) disable iff (clr)
      done && state_reg == spi_port_pkg::ST_MASTER && PORT_ENABLE_IN ##1 1'b1
      |=> SERIAL_CLOCK_PIN_OUT == $past(CLOCK_IDLE_POLARITY_IN))
      else $error("clock pin not idle after byte");
   a_fault_stops: assert property (@(posedge CORE_CLK_IN) disable iff (clr)
      fault_ev && !freeze |=> MODE_FAULT_OUT && state_reg == spi_port_pkg::ST_IDLE)
      else $error("mode fault not taken");

endmodule // spi_port

// [logic/spi_port_pkg.sv]
// shared constants and types for the serial peripheral port
// assumes a single bus clock domain; no bus, all settings are plain ports
package spi_port_pkg;

   // ************************************************************
   // widths and depths
   // ************************************************************
   localparam int DATA_W = 8;
   localparam int TX_FIFO_DEPTH = 16;
   localparam int SEL_W = 3;
   localparam int DIV_CNT_W = 11;
   localparam int EDGE_W = 5;

   // ************************************************************
   // counts and reset values
   // ************************************************************
   localparam logic [EDGE_W-1:0] EDGE_ZERO = 5'h00;
   localparam logic [EDGE_W-1:0] FIRST_EDGE = 5'h01;
   localparam logic [EDGE_W-1:0] EDGES_PER_BYTE = 5'h10;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic PIN_IDLE = 1'b0;
   localparam logic SELECT_IDLE = 1'b1;

   typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} state_t;

endpackage

// [logic/tx_fifo.sv]
// synchronous fifo in the transmit data path
// assumes DEPTH is a power of two; one clock, synchronous active-high clear
`timescale 1ns/1ps
module tx_fifo #(
   parameter int WIDTH = spi_port_pkg::DATA_W,
   parameter int DEPTH = spi_port_pkg::TX_FIFO_DEPTH
) (
   input wire logic clk_in,
   input wire logic clr_in,
   input wire logic flush_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
   logic [CNT_W-1:0] count_reg, count_next;
   logic push, pop;

   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_valid_out = count_reg != '0;
   assign out_data_out = mem_reg[rd_ptr_reg];

   always_comb
   begin
      count_next = count_reg;
      if (push && !pop)
         count_next = count_reg + CNT_W'(1);
      else if (pop && !push)
         count_next = count_reg - CNT_W'(1);
   end

   always_ff @(posedge clk_in)
   begin
      if (push)
         mem_reg[wr_ptr_reg] <= in_data_in;
   end

   always_ff @(posedge clk_in)
   begin
      if (clr_in || flush_in)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         in_ready_out <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
         count_reg <= count_next;
         // ready kept as a flop so the source never sees a combinational path
         in_ready_out <= count_next != FULL_COUNT;
      end
   end

endmodule // tx_fifo

// [logic/bit_rate_gen.sv]
// master bit-rate generator: half-bit ticks from the bus clock
// assumes prescale and rate selects stay steady while a byte is shifting
`timescale 1ns/1ps
module bit_rate_gen #(
   parameter int SEL_W = spi_port_pkg::SEL_W,
   parameter int CNT_W = spi_port_pkg::DIV_CNT_W
) (
   input wire logic clk_in,
   input wire logic clr_in,
   input wire logic run_in,
   input wire logic hold_in,
   input wire logic [SEL_W-1:0] prescale_in,
   input wire logic [SEL_W-1:0] rate_in,
   output logic half_tick_out
);
   logic [CNT_W-1:0] cnt_reg, lim, gap_reg;

   // half a bit period is (prescale + 1) * 2^rate bus clocks
   function automatic logic [CNT_W-1:0] half_limit(input logic [SEL_W-1:0] p,
                                                    input logic [SEL_W-1:0] r);
      logic [CNT_W-1:0] base;
      base = CNT_W'(p) + CNT_W'(1);
      return (base << r) - CNT_W'(1);
   endfunction

   assign lim = half_limit(prescale_in, rate_in);

   always_ff @(posedge clk_in)
   begin
      if (clr_in || !run_in)
      begin
         cnt_reg <= '0;
         half_tick_out <= 1'b0;
      end
      else if (hold_in)
         half_tick_out <= 1'b0;
      else if (cnt_reg == lim)
      begin
         cnt_reg <= '0;
         half_tick_out <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + CNT_W'(1);
         half_tick_out <= 1'b0;
      end
   end

   // cycles since the previous tick, zero when unknown
   always_ff @(posedge clk_in)
   begin
      if (clr_in || !run_in || hold_in)
         gap_reg <= '0;
      else if (half_tick_out)
         gap_reg <= CNT_W'(1);
      else if (gap_reg != '0)
         gap_reg <= gap_reg + CNT_W'(1);
   end

   a_tick_spacing: assert property (@(posedge clk_in) disable iff (clr_in)
      half_tick_out && gap_reg != '0 && $stable(lim) |-> gap_reg == lim + CNT_W'(1))
      else $error("half-bit tick spacing does not match divider");

endmodule // bit_rate_gen

// [sim/spi_slave_model.sv]
// behavioural serial slave facing the port in master mode
// assumes clock idle low, sample on rising edge, msb first
`timescale 1ns/1ps
module spi_slave_model (
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic sel_n_in,
   output logic miso_out,
   output logic [7:0] got_out,
   output logic got_tgl_out
);
   logic [7:0] sh_reg = 8'h5A;
   logic [7:0] cap_reg = 8'h00;
   logic [7:0] n_reg = 8'h00;
   int cnt = 0;
   initial got_tgl_out = 1'b0;
   // released line shows the inverse of the next bit to drive, never a stale copy
   assign miso_out = sel_n_in ? ~sh_reg[7] : sh_reg[7];
   always @(negedge sel_n_in)
   begin
      cnt = 0;
      sh_reg = 8'h5A ^ n_reg;
   end
   always @(posedge sck_in)
   if (!sel_n_in)
   begin
      cap_reg = {cap_reg[6:0], mosi_in};
      cnt = cnt + 1;
      if (cnt == 8)
      begin
         got_out = cap_reg;
         got_tgl_out = ~got_tgl_out;
         n_reg = n_reg + 8'h01;
         sh_reg = 8'h5A ^ n_reg;
         cnt = 0;
      end
   end
   // no shift after the eighth sample: the next reply is already loaded
   always @(negedge sck_in)
   if (!sel_n_in && cnt != 0)
      sh_reg = {sh_reg[6:0], 1'b0};
endmodule // spi_slave_model

// [sim/spi_port_tb.sv]
// self-checking bench: port as master against the slave model
// assumes the design package is compiled first
`timescale 1ns/1ps
module spi_port_tb;
   logic clk = 0, rst_n = 0, en = 0, mst = 0, pol = 0, fde = 0, soe = 0, txv = 0, rxr = 0;
   logic sw = 0, hd = 0, mfc = 0, ssd = 1;
   logic [2:0] pre = 3'h1, rate = 3'h1;
   logic [7:0] txd = 8'h00, b, e;
   logic tx_rdy, tx_empty, rx_full, mf, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
   logic ss_o, ss_oe, m_miso, got_tgl;
   logic [7:0] rxd, got;
   int n_fail = 0, tests_run = 0, w;
   logic [7:0] q_tx[$], q_rx[$];
   // weak pull-down on clock, pull-ups on data out and select
   wire sck = sck_oe ? sck_o : 1'b0;
   wire mosi = mosi_oe ? mosi_o : 1'b1;
   // select pulled up unless the bench pulls it low to provoke a mode fault
   wire ss = ss_oe ? ss_o : ssd;
   wire miso = miso_oe ? miso_o : m_miso;
   initial forever #20 clk = ~clk;
   spi_port uut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .LIGHT_STOP_IN(1'b0), .DEEP_STOP_IN(1'b0),
      .PORT_ENABLE_IN(en), .MASTER_MODE_IN(mst), .CLOCK_IDLE_POLARITY_IN(pol),
      .CLOCK_EDGE_PHASE_IN(1'b0), .LOW_BIT_FIRST_IN(1'b0), .SINGLE_WIRE_SELECT_IN(sw),
      .HALF_DUPLEX_DRIVE_ENABLE_IN(hd), .FAULT_DETECT_ENABLE_IN(fde),
      .SELECT_OUTPUT_ENABLE_IN(soe), .PRESCALE_SELECT_IN(pre), .RATE_DIVIDER_SELECT_IN(rate),
      .TX_VALID_IN(txv), .TX_DATA_IN(txd), .TX_READY_OUT(tx_rdy),
      .TRANSMIT_EMPTY_FLAG_OUT(tx_empty), .RX_DATA_OUT(rxd), .RECEIVE_FULL_FLAG_OUT(rx_full),
      .RX_READ_IN(rxr), .MODE_FAULT_OUT(mf), .MODE_FAULT_CLEAR_IN(mfc),
      .SERIAL_CLOCK_PIN_IN(sck), .SERIAL_CLOCK_PIN_OUT(sck_o), .SERIAL_CLOCK_PIN_OE_OUT(sck_oe),
      .MOSI_IN(mosi), .MOSI_OUT(mosi_o), .MOSI_OE_OUT(mosi_oe), .MISO_IN(miso),
      .MISO_OUT(miso_o), .MISO_OE_OUT(miso_oe), .SLAVE_SELECT_IN(ss),
      .SLAVE_SELECT_OUT(ss_o), .SLAVE_SELECT_OE_OUT(ss_oe));
   spi_slave_model model (.sck_in(sck), .mosi_in(mosi), .sel_n_in(ss), .miso_out(m_miso),
      .got_out(got), .got_tgl_out(got_tgl));
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] sn);
      tests_run++;
      if (sn !== ex)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, ex, sn);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ************************************************************
   // result watchers: oldest note against each observed result
   // ************************************************************
   always @(posedge clk)
   if (rx_full === 1'b1 && rxr === 1'b0)
   begin
      e = q_rx.size() ? q_rx.pop_front() : 8'hxx;
      chk("rx data", e, rxd);
      rxr <= 1'b1;
   end
   else
      rxr <= 1'b0;
   always @(got_tgl)
   if ($time > 0)
   begin
      e = q_tx.size() ? q_tx.pop_front() : 8'hxx;
      chk("mosi byte", e, got);
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      void'($urandom(32'hef7b7ea1));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("reset oe", 8'h00, {sck_oe, mosi_oe, miso_oe, ss_oe});
      chk("reset flags", 8'h01, {rx_full, tx_empty});
      $display("test reset done");
      mst <= 1'b1;
      fde <= 1'b1;
      soe <= 1'b1;
      en <= 1'b1;
      pre <= 3'($urandom_range(1, 2));
      rate <= 3'($urandom_range(1, 2));
      repeat (3) @(posedge clk);
      chk("master oe", 8'h0D, {sck_oe, mosi_oe, miso_oe, ss_oe});
      chk("idle clock", 8'h00, sck_o);
      // twenty bytes overfill the fifo so ready must refuse on the way
      for (int i = 0; i < 20; i++)
      begin
         b = 8'($urandom);
         txd <= b;
         txv <= 1'b1;
         w = 0;
         do @(posedge clk); while (tx_rdy !== 1'b1 && ++w < 5000);
         if (w >= 5000)
            chk("tx ready", 8'h01, 8'h00);
         q_tx.push_back(b);
         q_rx.push_back(8'h5A ^ 8'(i));
      end
      txv <= 1'b0;
      w = 0;
      while ((q_tx.size() || q_rx.size() || tx_empty !== 1'b1) && w++ < 20000)
         @(posedge clk);
      if (w > 20000)
         chk("drain", 8'h00, 8'h01);
      $display("test exchange done");
      txd <= 8'hC3;
      txv <= 1'b1;
      @(posedge clk);
      txv <= 1'b0;
      repeat (30) @(posedge clk);
      en <= 1'b0;
      repeat (2) @(posedge clk);
      chk("off oe", 8'h00, {sck_oe, mosi_oe, miso_oe, ss_oe});
      chk("off flags", 8'h01, {rx_full, tx_empty});
      $display("test abort done");
      pol <= 1'b1;
      en <= 1'b1;
      repeat (3) @(posedge clk);
      chk("idle high", 8'h03, {sck_oe, sck_o});
      $display("test polarity done");
      soe <= 1'b0;
      ssd <= 1'b0;
      repeat (3) @(posedge clk);
      chk("mode fault", 8'h01, mf);
      ssd <= 1'b1;
      mfc <= 1'b1;
      @(posedge clk);
      mfc <= 1'b0;
      repeat (2) @(posedge clk);
      chk("fault clear", 8'h00, mf);
      $display("test fault done");
      sw <= 1'b1;
      hd <= 1'b0;
      repeat (3) @(posedge clk);
      chk("shared pin in", 8'h00, {mosi_oe, miso_oe});
      hd <= 1'b1;
      repeat (2) @(posedge clk);
      chk("shared pin out", 8'h02, {mosi_oe, miso_oe});
      $display("test single wire done");
      give_verdict();
   end
endmodule // spi_port_tb
